//--- rtl/rtc_pkg.sv
package rtc_pkg;

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  localparam int          XTAL_HZ      = 32768;
  localparam int          STAGE1_HZ    = 20720;
  localparam int          ACC_W        = 15;
  localparam logic [15:0] ACC_MOD      = 16'(XTAL_HZ);
  localparam logic [15:0] ACC_INC      = 16'(STAGE1_HZ);
  localparam int          RIPPLE_W     = 9;
  localparam logic [8:0]  RIPPLE_LAST  = 9'h1FF;
  localparam logic [2:0]  JOHNSON_LAST = 3'h4;

  // ----------------------------------------------------------------
  // Register addresses and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_TENTHS  = 4'h1;
  localparam logic [3:0]  ADDR_UNITS   = 4'h2;
  localparam logic [3:0]  ADDR_TENS    = 4'h3;
  localparam int          CTRL_FLAG    = 3;
  localparam int          CTRL_HALT    = 2;

  // ----------------------------------------------------------------
  // Counter limits and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  DIGIT_MAX    = 4'h9;
  localparam logic [3:0]  TENS_MAX     = 4'h5;
  localparam logic [3:0]  DIGIT_RST    = 4'h0;
  localparam logic        HALT_RST     = 1'b0;
  localparam logic        FLAG_RST     = 1'b0;

endpackage

//--- rtl/rtc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Asynchronous inputs and filtered result
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } rtc_sync_state_type;

  rtc_sync_state_type st;
  rtc_sync_state_type next_st;

  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s2[i];
      end
    end
  end

  // Pins idle high after reset, matching their pull-ups
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.filt;

endmodule
`default_nettype wire

//--- rtl/rtc_timebase.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_timebase (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Crystal oscillator
  input  wire logic       xtal_in,
  // Processor bus
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [3:0] addr,
  input  wire logic [3:0] data_in,
  output logic      [3:0] data_out,
  output logic            data_oe,
  // Test and status
  input  wire logic       test_mode,
  output logic            int_out,
  output logic            setting_pulse,
  output logic            halted
);

  typedef struct packed {
    logic [rtc_pkg::ACC_W-1:0]    acc;
    logic [rtc_pkg::RIPPLE_W-1:0] ripple;
    logic [2:0]                   johnson;
    logic                         pulse;
    logic [3:0]                   tenths;
    logic [3:0]                   units;
    logic [3:0]                   tens;
    logic                         flag;
    logic                         halt;
    logic [3:0]                   dout;
    logic                         xtal_d;
    logic                         wr_d;
    logic                         rd_d;
  } rtc_state_type;

  rtc_state_type st;
  rtc_state_type next_st;

  logic [4:0]  ctl_f;
  logic [7:0]  bus_f;
  logic        xtal_f;
  logic        test_f;
  logic        cs_f;
  logic        rd_f;
  logic        wr_f;
  logic [3:0]  addr_f;
  logic [3:0]  wdata_f;
  logic        wr_win;
  logic        rd_win;
  logic        xtal_edge;
  logic        wr_end;
  logic        rd_end;
  logic [15:0] sum;
  logic [4:0]  inc_t;
  logic [4:0]  inc_u;
  logic [4:0]  inc_s;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Test pin idles low, so it enters the high-reset filter inverted
  rtc_sync #(.W(5)) u_sync_ctl (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({~test_mode, xtal_in, cs_n, rd_n, wr_n}),
    .dout   (ctl_f)
  );

  rtc_sync #(.W(8)) u_sync_bus (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({addr, data_in}),
    .dout   (bus_f)
  );

  assign test_f  = ~ctl_f[4];
  assign xtal_f  = ctl_f[3];
  assign cs_f    = ctl_f[2];
  assign rd_f    = ctl_f[1];
  assign wr_f    = ctl_f[0];
  assign addr_f  = bus_f[7:4];
  assign wdata_f = bus_f[3:0];

  assign wr_win    = !cs_f && !wr_f;
  assign rd_win    = !cs_f && !rd_f;
  assign xtal_edge = xtal_f && !st.xtal_d;
  assign wr_end    = st.wr_d && !wr_win;
  assign rd_end    = st.rd_d && !rd_win;

  // BCD step: carry in the top bit, digit below
  function automatic logic [4:0] digit_inc(input logic [3:0] v,
                                           input logic [3:0] lim);
    logic [4:0] r;
    r = {1'b0, v + 4'h1};
    if (v >= lim) begin
      r = {1'b1, 4'h0};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Divider chain, counters and register access
  // ----------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.xtal_d = xtal_f;
    next_st.wr_d   = wr_win;
    next_st.rd_d   = rd_win;
    sum   = {1'b0, st.acc} + rtc_pkg::ACC_INC;
    inc_t = digit_inc(st.tenths, rtc_pkg::DIGIT_MAX);
    inc_u = digit_inc(st.units, rtc_pkg::DIGIT_MAX);
    inc_s = digit_inc(st.tens, rtc_pkg::TENS_MAX);
    // Read end clears; a setting pulse later in this block wins
    if (rd_end && addr_f == rtc_pkg::ADDR_CTRL) begin
      next_st.flag = 1'b0;
    end
    if (xtal_edge) begin
      // Falling edge of the setting pulse advances time
      if (st.pulse) begin
        next_st.pulse = 1'b0;
        next_st.flag  = 1'b1;
        next_st.tenths = inc_t[3:0];
        if (inc_t[4]) begin
          next_st.units = inc_u[3:0];
          if (inc_u[4]) begin
            next_st.tens = inc_s[3:0];
          end
        end
      end
      if (sum >= rtc_pkg::ACC_MOD) begin
        // Fractional divider: carry out of the phase accumulator
        next_st.acc    = sum[rtc_pkg::ACC_W-1:0];
        next_st.ripple = st.ripple + 9'h001;
        if (st.ripple == rtc_pkg::RIPPLE_LAST) begin
          next_st.johnson = {st.johnson[1:0], ~st.johnson[2]};
          if (st.johnson == rtc_pkg::JOHNSON_LAST) begin
            next_st.pulse = 1'b1;
          end
        end
      end else begin
        next_st.acc = sum[rtc_pkg::ACC_W-1:0];
      end
    end
    // Writes override a tick landing in the same cycle
    if (wr_end) begin
      case (addr_f)
        rtc_pkg::ADDR_CTRL: begin
          next_st.halt = wdata_f[rtc_pkg::CTRL_HALT];
        end
        rtc_pkg::ADDR_UNITS: begin
          next_st.units = wdata_f;
        end
        rtc_pkg::ADDR_TENS: begin
          next_st.tens = wdata_f;
        end
        default: begin
        end
      endcase
    end
    if (next_st.halt) begin
      next_st.tenths = rtc_pkg::DIGIT_RST;
    end
    case (addr_f)
      rtc_pkg::ADDR_CTRL: begin
        next_st.dout = 4'h0;
        next_st.dout[rtc_pkg::CTRL_FLAG] = st.flag;
      end
      rtc_pkg::ADDR_TENTHS: begin
        next_st.dout = st.tenths;
      end
      rtc_pkg::ADDR_UNITS: begin
        next_st.dout = st.units;
      end
      rtc_pkg::ADDR_TENS: begin
        next_st.dout = st.tens;
      end
      default: begin
        next_st.dout = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st        <= '0;
      st.halt   <= rtc_pkg::HALT_RST;
      st.flag   <= rtc_pkg::FLAG_RST;
      st.xtal_d <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out      = st.dout;
  assign data_oe       = rd_win;
  // Interrupt timer lives elsewhere; pin idles low outside test
  assign int_out       = test_f ? xtal_f : 1'b0;
  assign setting_pulse = st.pulse;
  assign halted        = st.halt;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_pulse_fall;
    $fell(st.pulse);
  endsequence

  sequence s_ctrl_read_end;
    rd_end && addr_f == rtc_pkg::ADDR_CTRL;
  endsequence

  a_flag_on_fall: assert property (s_pulse_fall |-> st.flag)
    else $error("flag not set by setting pulse");
  a_flag_rise_src: assert property ($rose(st.flag) |-> s_pulse_fall)
    else $error("flag rose outside pulse fall");
  a_tenths_when: assert property
    ($changed(st.tenths) |-> $fell(st.pulse) || st.halt)
    else $error("tenths changed outside pulse fall");
  a_halt_zero: assert property (st.halt |-> st.tenths == 4'h0)
    else $error("tenths not zero while halted");
  a_flag_bit3: assert property
    (rd_win && addr_f == rtc_pkg::ADDR_CTRL |=>
     data_out[3] == $past(st.flag))
    else $error("control read does not show flag");
  a_read_clears: assert property
    (s_ctrl_read_end ##0 !(xtal_edge && st.pulse) |=> !st.flag)
    else $error("flag not cleared by control read");
  a_bus_window: assert property (data_oe |-> !cs_f && !rd_f)
    else $error("bus driven outside read strobe");
  a_test_osc: assert property
    (test_f |-> int_out == xtal_f ##1 !test_f || int_out == xtal_f)
    else $error("oscillator not on interrupt pin");
  a_write_units: assert property
    (wr_end && addr_f == rtc_pkg::ADDR_UNITS |=>
     st.units == $past(wdata_f))
    else $error("units not captured at write end");
  a_pulse_len: assert property (st.pulse && xtal_edge |=> !st.pulse)
    else $error("setting pulse outlived a crystal period");
  a_pulse_end: assert property ($fell(st.pulse) |-> $past(xtal_edge))
    else $error("setting pulse ended between crystal edges");

endmodule
`default_nettype wire

//--- testbench/rtc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_cpu_model (
  // Clock
  input  wire logic       clk,
  // Strobe bus towards the clock
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [3:0] addr,
  output logic      [3:0] data_in,
  // Read return
  input  wire logic [3:0] data_out,
  input  wire logic       data_oe
);
  // ----------------------------------------------------------------
  // Idle lines
  // ----------------------------------------------------------------
  // Released lines sit high, as the pull-ups leave them
  initial begin
    cs_n    = 1'b1;
    rd_n    = 1'b1;
    wr_n    = 1'b1;
    addr    = 4'hF;
    data_in = 4'hF;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Five clocks a phase clears the three-flop input filter
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [3:0] d,
                           input logic sel);
    addr    = a;
    data_in = d;
    step(5);
    cs_n = ~sel;
    wr_n = 1'b0;
    step(6);
    wr_n = 1'b1;
    cs_n = 1'b1;
    step(6);
    addr    = 4'hF;
    data_in = 4'hF;
    step(2);
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [3:0] d,
                          output logic oe);
    addr = a;
    step(5);
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(8);
    d    = data_out;
    oe   = data_oe;
    rd_n = 1'b1;
    cs_n = 1'b1;
    step(6);
    addr = 4'hF;
    step(2);
  endtask
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       clk;
  logic       arst_n;
  logic       xtal_in;
  logic       test_mode;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [3:0] addr;
  logic [3:0] data_in;
  logic [3:0] data_out;
  logic       data_oe;
  logic       int_out;
  logic       setting_pulse;
  logic       halted;
  logic [3:0] rdat;
  logic       roe;
  int         n;
  int         mismatches = 0;
  int         samples_checked = 0;

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  // Crystal sped up to six clocks a period so a tick fits the run
  initial clk = 1'b0;
  initial xtal_in = 1'b0;
  always #4 clk = ~clk;
  always #24 xtal_in = ~xtal_in;

  rtc_timebase u_rtc_timebase (.clk(clk), .arst_n(arst_n),
    .xtal_in(xtal_in), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .test_mode(test_mode), .int_out(int_out),
    .setting_pulse(setting_pulse), .halted(halted));

  rtc_cpu_model u_rtc_cpu_model (.clk(clk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check4(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t nibble got %h want %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t bit got %b want %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    u_rtc_cpu_model.bus_write(a, d, 1'b1);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [3:0] exp);
    u_rtc_cpu_model.bus_read(a, rdat, roe);
    check4(rdat, exp);
    check1(roe, 1'b1);
    check1(data_oe, 1'b0);
  endtask

  task automatic count_high(output int cnt);
    cnt = 0;
    repeat (12) begin
      @(negedge clk);
      if (int_out === 1'b1) cnt++;
    end
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    arst_n    = 1'b0;
    test_mode = 1'b0;
    repeat (5) @(negedge clk);
    check1(data_oe, 1'b0);
    check1(halted, 1'b0);
    arst_n = 1'b1;
    count_high(n);
    check1(logic'(n == 0), 1'b1);
    test_mode = 1'b1;
    u_rtc_cpu_model.step(8);
    count_high(n);
    check1(logic'(n >= 5 && n <= 7), 1'b1);
    test_mode = 1'b0;
    rd_chk(rtc_pkg::ADDR_CTRL, 4'h0);
    rd_chk(4'h4, 4'h0);
    wr(rtc_pkg::ADDR_UNITS, 4'h7);
    wr(rtc_pkg::ADDR_TENS, 4'h5);
    wr(rtc_pkg::ADDR_TENTHS, 4'h6);
    u_rtc_cpu_model.bus_write(rtc_pkg::ADDR_UNITS, 4'h3, 1'b0);
    rd_chk(rtc_pkg::ADDR_UNITS, 4'h7);
    rd_chk(rtc_pkg::ADDR_TENS, 4'h5);
    rd_chk(rtc_pkg::ADDR_TENTHS, 4'h0);
    // Roughly 4858 crystal periods between ticks
    n = 0;
    while (setting_pulse !== 1'b1 && n < 35000) begin
      @(negedge clk);
      n++;
    end
    check1(setting_pulse, 1'b1);
    n = 0;
    while (setting_pulse === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check1(logic'(n >= 5 && n <= 7), 1'b1);
    u_rtc_cpu_model.step(3);
    rd_chk(rtc_pkg::ADDR_TENTHS, 4'h1);
    rd_chk(rtc_pkg::ADDR_UNITS, 4'h7);
    rd_chk(rtc_pkg::ADDR_CTRL, 4'h8);
    rd_chk(rtc_pkg::ADDR_CTRL, 4'h0);
    wr(rtc_pkg::ADDR_CTRL, 4'h4);
    check1(halted, 1'b1);
    rd_chk(rtc_pkg::ADDR_TENTHS, 4'h0);
    give_verdict;
  end

  // Hang guard: one tick plus bus traffic is about 29300 clocks
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    give_verdict;
  end
endmodule

`default_nettype wire
